// ---- core/imt_defines.svh ----
// Purpose: Constants for the inactivity monitor timer
// Assumes: 25 MHz system clock, one 16-bit control/status I/O port
// Notes:   Offsets, field positions, reset values and timing counts
//
// Functional notes
// (RULE_01) Request-activity enable gates all pending request bits; requests 8,7,0 individually maskable.
// (RULE_02) Timeout counter is 17 bits; read-only bit 14 shows counter bit twelve.
// (RULE_03) Test mode clocks the monitor faster and bypasses nine counter stages.
// (RULE_04) Activity latch sets on any unmasked activity, regardless of master enable.
// (RULE_05) Writing zero clears the activity latch; writing one leaves it alone.
// (RULE_06) Timeout without activity sets inactivity-detected and requests local attention.
// (RULE_07) Zero to inactivity-detected or master enable clears detected, after and before flags.
// (RULE_08) Activity while inactivity-detected is set sets the read-only after flag.
// (RULE_09) Activity clearing the counter before detection sets the read-only before flag.
// (RULE_10) Software counting timeout periods resets its count when the before flag is set.
// (RULE_11) Master enable starts counting; each unmasked activity clears the counter.
// (RULE_12) Clearing master enable puts the monitor idle with counting stopped.
// (RULE_13) After a timeout the counter clears and a new sequence starts at once.
// (RULE_14) Coarse field bits 7..4 give value times 64 seconds.
// (RULE_15) Software changes timeout fields only while disabled; fields readable any time.
// (RULE_16) Bits 15, 13..11, 8..0 read/write; bits 14, 10, 9 read-only.
// (RULE_17) Transitions on the selected power input also assert local attention.
// (RULE_18) Fine field bits 3..0 give value times 7.8 milliseconds.
// (RULE_19) Timeout compared against the counter is fine plus coarse delay.
// (RULE_20) Request, in-service, power, NMI, DMA and I/O sources count unless masked.
// (RULE_21) Activity from other clock domains is synchronised before use.
`ifndef IMT_DEFINES_SVH
`define IMT_DEFINES_SVH

`define IMT_CTRL_ADDR     16'hB072
`define IMT_CTRL_RST      16'h0000

`define IMT_BIT_REQ_EN    15
`define IMT_BIT_COUNTER_BIT_TWELVE      14
`define IMT_BIT_TEST      13
`define IMT_BIT_LATCH     12
`define IMT_BIT_INACTIVITY_DETECTED     11
`define IMT_BIT_AFTER     10
`define IMT_BIT_BEFORE    9
`define IMT_BIT_ENABLE    8
`define IMT_COARSE_HI     7
`define IMT_COARSE_LO     4
`define IMT_FINE_HI       3
`define IMT_FINE_LO       0

`define IMT_CASCADE_BIT   2
`define IMT_CNT_W         17
`define IMT_CNT_TAP       12
`define IMT_BYPASS_STAGES 9
`define IMT_COARSE_WEIGHT 8192

`define IMT_CLK_NS        40
`define IMT_FINE_STEP_NS  7800000
`define IMT_FINE_TICK_CYC ((`IMT_FINE_STEP_NS + `IMT_CLK_NS - 1) / `IMT_CLK_NS)
`define IMT_TEST_TICK_CYC 16

`endif

// ---- core/imt_pkg.sv ----
// Purpose: Types for the inactivity monitor timer
// Assumes: Constants come from imt_defines.svh
// Notes:   Types only
package imt_pkg;
   typedef enum logic [0:0] {
      IMT_IDLE = 1'b0,
      IMT_RUN  = 1'b1
   } imt_state_t;
endpackage

// ---- core/imt_sync.sv ----
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
module imt_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   if (W < 1) $error("imt_sync: W must be at least 1");

   // Stage one feeds only stage two
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= async_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule // imt_sync

// ---- core/imt_tick.sv ----
// Purpose: Timebase prescaler for the timeout counter
// Assumes: run low holds the prescaler cleared
// Notes:   fast selects the short test period
`timescale 1ns/1ps
module imt_tick #(
   parameter int NORM_DIV = 195000,
   parameter int TEST_DIV = 16
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic fast,
   output logic      tick
);
   localparam int PW = $clog2(NORM_DIV + 1);
   logic [PW-1:0] pre_q, pre_d;
   logic          tick_q, tick_d;

   if (NORM_DIV < 2 || TEST_DIV < 2 || TEST_DIV > NORM_DIV)
      $error("imt_tick: dividers must be at least 2, test not above normal");

   always_comb begin
      pre_d  = pre_q + PW'(1);
      tick_d = 1'b0;
      if (!run) begin
         pre_d = '0;
      end else if (pre_q >= (fast ? PW'(TEST_DIV - 1) : PW'(NORM_DIV - 1))) begin
         pre_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule // imt_tick

// ---- core/imt_top.sv ----
// Purpose: Inactivity monitor: timeout counter, status flags, control port
// Assumes: Mask logic outside supplies per-bit masks and pre-masked sources
// Notes:   Register reached at its I/O port address; read data one cycle later
`timescale 1ns/1ps
`include "imt_defines.svh"
module imt_top
   import imt_pkg::*;
#(
   parameter int FINE_TICK_CYC = `IMT_FINE_TICK_CYC,
   parameter int TEST_TICK_CYC = `IMT_TEST_TICK_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_wr_en,
   input  wire logic        io_rd_en,
   input  wire logic [15:0] io_wdata,
   output logic      [15:0] io_rdata,
   output logic             io_rd_valid,
   input  wire logic [15:0] pending_request_bits,
   input  wire logic [15:0] in_service_bits,
   input  wire logic [15:0] request_mask,
   input  wire logic [15:0] service_mask,
   input  wire logic [3:0]  other_activity,
   input  wire logic        selected_power_input,
   output logic             local_attention_out,
   output logic             monitor_running
);
   localparam int CW = `IMT_CNT_W;
   localparam int SW = 16 + 16 + 4 + 1;

   if (FINE_TICK_CYC < 2 || TEST_TICK_CYC < 2 || TEST_TICK_CYC > FINE_TICK_CYC)
      $error("imt_top: tick counts must be at least 2, test not above normal");

   ////////////////////////////////////////////////////////////////////////////
   // Port decode

   function automatic logic port_hit(input logic [15:0] a);
      if (a == `IMT_CTRL_ADDR) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   logic wr_hit, rd_hit;
   assign wr_hit = io_wr_en && port_hit(io_addr);
   assign rd_hit = io_rd_en && port_hit(io_addr);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   logic [SW-1:0] raw_in, syn_in;
   logic [15:0]   req_s, srv_s;
   logic [3:0]    oth_s;
   logic          pwr_s;

   assign raw_in = {pending_request_bits, in_service_bits, other_activity,
                    selected_power_input};

   imt_sync #(.W(SW)) u_sync ( // RULE_21
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (raw_in),
      .sync_out (syn_in)
   );

   assign req_s = syn_in[SW-1 -: 16];
   assign srv_s = syn_in[SW-17 -: 16];
   assign oth_s = syn_in[4:1];
   assign pwr_s = syn_in[0];

   ////////////////////////////////////////////////////////////////////////////
   // Activity detection

   logic [15:0] ctrl_q, ctrl_d;
   imt_state_t  state_q, state_d;
   logic [15:0] req_term, srv_term, cascade_keep;
   logic        act;

   assign cascade_keep = ~(16'h0001 << `IMT_CASCADE_BIT);

   always_comb begin
      // Cascade line carries no activity of its own
      srv_term = srv_s & ~service_mask & cascade_keep;                 // RULE_20
      req_term = 16'h0000;
      if (ctrl_q[`IMT_BIT_REQ_EN]) begin
         req_term = req_s & ~request_mask & cascade_keep;              // RULE_01
      end
      act = (|req_term) || (|srv_term) || (|oth_s);                   // RULE_20
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and status

   logic        latch_q, latch_d;
   logic        inactivity_detected_q, inactivity_detected_d;
   logic        after_q, after_d;
   logic        before_q, before_d;
   logic        attn_q, attn_d;
   logic        pwr_prev_q, pwr_prev_d;
   logic        flag_clr, timeout, pwr_edge;

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_hit) begin
         // Read-only positions never take write data
         ctrl_d = io_wdata & 16'hB9FF;                                 // RULE_16
      end
      flag_clr = wr_hit && (!io_wdata[`IMT_BIT_INACTIVITY_DETECTED]
                            || !io_wdata[`IMT_BIT_ENABLE]);            // RULE_07
      pwr_edge = pwr_s ^ pwr_prev_q;
      pwr_prev_d = pwr_s;

      latch_d = latch_q;
      if (wr_hit && !io_wdata[`IMT_BIT_LATCH]) begin
         latch_d = 1'b0;                                               // RULE_05
      end
      if (act) begin
         latch_d = 1'b1;                                               // RULE_04
      end

      inactivity_detected_d  = flag_clr ? 1'b0 : inactivity_detected_q;
      after_d  = flag_clr ? 1'b0 : after_q;
      before_d = flag_clr ? 1'b0 : before_q;
      attn_d   = flag_clr ? 1'b0 : attn_q;
      // Sets win over a clear in the same cycle
      if (timeout) begin
         inactivity_detected_d = 1'b1;                                               // RULE_06
         attn_d  = 1'b1;                                               // RULE_06
      end
      if (act && inactivity_detected_q) begin
         after_d = 1'b1;                                               // RULE_08
      end
      if (act && state_q == IMT_RUN && !inactivity_detected_q) begin
         before_d = 1'b1;                                              // RULE_09
      end
      if (pwr_edge) begin
         attn_d = 1'b1;                                                // RULE_17
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q     <= `IMT_CTRL_RST;
         latch_q    <= 1'b0;
         inactivity_detected_q    <= 1'b0;
         after_q    <= 1'b0;
         before_q   <= 1'b0;
         attn_q     <= 1'b0;
         pwr_prev_q <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         latch_q    <= latch_d;
         inactivity_detected_q    <= inactivity_detected_d;
         after_q    <= after_d;
         before_q   <= before_d;
         attn_q     <= attn_d;
         pwr_prev_q <= pwr_prev_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timeout counter and state

   logic [CW-1:0] cnt_q, cnt_d, target, step;
   logic [CW:0]   sum;
   logic          tick;

   imt_tick #(
      .NORM_DIV (FINE_TICK_CYC),
      .TEST_DIV (TEST_TICK_CYC)
   ) u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (state_q == IMT_RUN),
      .fast  (ctrl_q[`IMT_BIT_TEST]),                                  // RULE_03
      .tick  (tick)
   );

   always_comb begin
      target = CW'(ctrl_q[`IMT_COARSE_HI:`IMT_COARSE_LO]) * CW'(`IMT_COARSE_WEIGHT) // RULE_14
             + CW'(ctrl_q[`IMT_FINE_HI:`IMT_FINE_LO]);                 // RULE_18 RULE_19
      // Test mode skips the low stages so long timeouts can be exercised
      step = ctrl_q[`IMT_BIT_TEST] ? CW'(1) << `IMT_BYPASS_STAGES : CW'(1); // RULE_03
      sum  = {1'b0, cnt_q} + {1'b0, step};
      state_d = ctrl_q[`IMT_BIT_ENABLE] ? IMT_RUN : IMT_IDLE;          // RULE_11 RULE_12
      cnt_d   = cnt_q;
      timeout = 1'b0;
      case (state_q)
         IMT_IDLE: begin
            cnt_d = '0;                                                // RULE_12
         end
         IMT_RUN: begin
            if (act) begin
               cnt_d = '0;                                             // RULE_11
            end else if (tick) begin
               if (sum >= {1'b0, target}) begin
                  cnt_d   = '0;                                        // RULE_13
                  timeout = 1'b1;                                      // RULE_06
               end else begin
                  cnt_d = sum[CW-1:0];
               end
            end
         end
         default: begin
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= IMT_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [15:0] view, rdata_q, rdata_d;
   logic        rvalid_q, rvalid_d, run_q;

   always_comb begin
      view = ctrl_q;                                                   // RULE_15
      view[`IMT_BIT_COUNTER_BIT_TWELVE]   = cnt_q[`IMT_CNT_TAP];                     // RULE_02
      view[`IMT_BIT_LATCH]  = latch_q;
      view[`IMT_BIT_INACTIVITY_DETECTED]  = inactivity_detected_q;
      view[`IMT_BIT_AFTER]  = after_q;
      view[`IMT_BIT_BEFORE] = before_q;
      rdata_d  = rd_hit ? view : 16'h0000;
      rvalid_d = io_rd_en;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
         run_q    <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         run_q    <= (state_d == IMT_RUN);
      end
   end

   assign io_rdata            = rdata_q;
   assign io_rd_valid         = rvalid_q;
   assign local_attention_out = attn_q;
   assign monitor_running     = run_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_req_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
      !ctrl_q[`IMT_BIT_REQ_EN] |-> req_term == 16'h0000)
      else $error("request bits counted while gate is off");

   a_counter_bit_twelve_view: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
      rd_hit |=> io_rdata[`IMT_BIT_COUNTER_BIT_TWELVE] == $past(cnt_q[`IMT_CNT_TAP]))
      else $error("bit 14 does not show counter bit twelve");

   a_test_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
      (state_q == IMT_RUN && tick && ctrl_q[`IMT_BIT_TEST] && !act && !timeout)
      |=> cnt_q == $past(cnt_q) + CW'(512))
      else $error("test mode step is not 512");

   a_latch_sets: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
      act |=> latch_q)
      else $error("activity latch missed an event");

   a_latch_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
      (wr_hit && !act) |=> latch_q == $past(io_wdata[`IMT_BIT_LATCH] && latch_q))
      else $error("activity latch write behaved wrongly");

   a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
      (flag_clr && !act && !timeout) |=> !inactivity_detected_q && !after_q && !before_q)
      else $error("status flags not cleared");

   a_timeout_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
      timeout |=> inactivity_detected_q && local_attention_out && cnt_q == '0)
      else $error("timeout did not flag and restart");

   a_after_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
      (act && inactivity_detected_q) |=> after_q)
      else $error("after flag not set");

   a_before_flag: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
      (act && state_q == IMT_RUN && !inactivity_detected_q) |=> before_q)
      else $error("before flag not set");

   a_act_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
      (act && state_q == IMT_RUN) |=> cnt_q == '0)
      else $error("activity did not clear counter");

   a_idle_stop: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
      (state_q == IMT_IDLE) [*2] |-> cnt_q == '0 && !timeout)
      else $error("counter moving while idle");

   a_power_attn: assert property (@(posedge clk) disable iff (!rst_n) // RULE_17
      pwr_edge |=> local_attention_out)
      else $error("power input transition lost");
endmodule // imt_top

// ---- test/imt_irq_model.sv ----
// Purpose: Interrupt controller stand-in taking the local attention request
// Assumes: Attention is a level, sampled on the rising clock edge
// Notes:   Also keeps the service routine's count of idle periods
`timescale 1ns/1ps
module imt_irq_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic attention,
   input  wire logic before_seen,
   output int        req_count,
   output int        idle_periods
);
   logic att_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         att_q        <= 1'b0;
         req_count    <= 0;
         idle_periods <= 0;
      end else begin
         att_q <= attention;
         // A held level is one request; only the rising edge enters service
         if (attention && !att_q) begin
            req_count    <= req_count + 1;
            idle_periods <= before_seen ? 1 : idle_periods + 1;
         end else if (before_seen) begin
            idle_periods <= 0;
         end
      end
   end
endmodule // imt_irq_model

// ---- test/inactivity_monitor_timer_tb.sv ----
// Purpose: Self-checking bench for the inactivity monitor timer
// Assumes: Short tick parameters; inputs change on the falling edge
// Notes:   Counter bit twelve is masked in read compares, its phase is not modelled
`timescale 1ns/1ps
`include "imt_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module inactivity_monitor_timer_tb;
   localparam int FT = 4;
   localparam int TT = 2;
   logic        clk, rst_n, io_wr_en, io_rd_en, sel_pwr, before_seen;
   logic [15:0] io_addr, io_wdata, io_rdata, pend, insvc, rmask, smask;
   logic [15:0] m_rw, rdv, bk;
   logic [3:0]  other;
   logic        io_rd_valid, att, running;
   logic [31:0] seed;
   int          err_count, checked, req_count, idle_periods, n;

   imt_top #(.FINE_TICK_CYC(FT), .TEST_TICK_CYC(TT)) dut (
      .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr_en(io_wr_en),
      .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rd_valid(io_rd_valid), .pending_request_bits(pend),
      .in_service_bits(insvc), .request_mask(rmask), .service_mask(smask),
      .other_activity(other), .selected_power_input(sel_pwr),
      .local_attention_out(att), .monitor_running(running));
   imt_irq_model irq (.clk(clk), .rst_n(rst_n), .attention(att),
      .before_seen(before_seen), .req_count(req_count), .idle_periods(idle_periods));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr_en = 1'b1;
      @(negedge clk);
      io_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(negedge clk);
      io_addr = a;
      io_rd_en = 1'b1;
      @(negedge clk);
      io_rd_en = 1'b0;
      `CHK(io_rd_valid, 1'b1)
      d = io_rdata;
   endtask

   // Model view: read/write fields plus the flags the scenario expects
   task automatic rc(input logic [15:0] fl);
      rd(16'hB072, rdv);
      `CHK(rdv & 16'hBFFF, m_rw | fl)
   endtask

   // Ones on latch and detect bits keep the flags while bit 8 is written one; with bit 8 zero the detect, after and before flags clear
   task automatic ctl(input logic [15:0] d);
      m_rw = d & 16'hA1FF;
      wr(16'hB072, d | 16'h1800);
   endtask

   task automatic clr(input logic [15:0] m);
      wr(16'hB072, (m_rw | 16'h1800) & ~m);
      m_rw = m_rw & ~m;
   endtask

   task automatic wait_att(input int lim);
      n = 0;
      while (att !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Held three cycles so the agreement filter cannot drop it
   task automatic burst(input logic [15:0] r, input logic [15:0] s, input logic [3:0] o);
      @(negedge clk);
      pend = r;
      insvc = s;
      other = o;
      cyc(3);
      pend = '0;
      insvc = '0;
      other = '0;
      cyc(6);
   endtask

   task automatic try_act(input logic [15:0] r, input logic [15:0] s,
                          input logic [3:0] o, input logic e);
      burst(r, s, o);
      rc(e ? 16'h1000 : 16'h0000);
      clr(16'h1000);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      cyc(4000);
      err_count++;
      $display("watchdog expired");
      end_sim();
   end

   initial begin
      {io_addr, io_wdata, pend, insvc, rmask, smask, m_rw} = '0;
      {io_wr_en, io_rd_en, sel_pwr, before_seen, other} = '0;
      err_count = 0;
      checked = 0;
      seed = 32'hA6E7398B;
      rst_n = 1'b0;
      cyc(12);
      rst_n = 1'b1;
      rc(16'h0000);
      rd(16'hB070, rdv);
      `CHK(rdv, 16'h0000)
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         wr(16'hB072, seed[15:0] & 16'hFEFF);
         m_rw = seed[15:0] & 16'hA0FF;
         rc(16'h0000);
      end
      wr(16'hB074, 16'hFFFF);
      rc(16'h0000);
      $display("test registers done");

      ctl(16'h0000);
      seed = xs(seed);
      bk = 16'h0001 << ((seed[3:0] == 4'h2) ? 4'h3 : seed[3:0]);
      try_act(bk, '0, 4'h0, 1'b0);
      try_act('0, bk, 4'h0, 1'b1);
      for (int i = 0; i < 4; i++) try_act('0, '0, 4'h1 << i, 1'b1);
      ctl(16'h8000);
      try_act(bk, '0, 4'h0, 1'b1);
      try_act(16'h0004, 16'h0004, 4'h0, 1'b0);
      rmask = bk;
      smask = bk;
      try_act(bk, bk, 4'h0, 1'b0);
      rmask = '0;
      smask = '0;
      $display("test activity sources done");

      ctl(16'h010F);
      cyc(2);
      `CHK(running, 1'b1)
      wait_att(120);
      `CHK(att, 1'b1)
      `CHK((n >= 50 && n <= 70), 1'b1)
      burst('0, '0, 4'h1);
      rc(16'h1C00);
      clr(16'h0800);
      rc(16'h1000);
      `CHK(att, 1'b0)
      clr(16'h0100);
      cyc(2);
      `CHK(running, 1'b0)
      rc(16'h1000);
      clr(16'h1000);
      $display("test timeout and after flag done");

      ctl(16'h0103);
      repeat (8) burst('0, '0, 4'h2);
      `CHK(att, 1'b0)
      rc(16'h1200);
      before_seen = 1'b1;
      cyc(1);
      before_seen = 1'b0;
      wait_att(60);
      `CHK(att, 1'b1)
      cyc(2);
      `CHK(idle_periods, 1)
      clr(16'h0100);
      rc(16'h1000);
      clr(16'h1000);
      $display("test before flag done");

      ctl(16'h2010);
      ctl(16'h2110);
      wait_att(100);
      `CHK((n >= 24 && n <= 44), 1'b1)
      `CHK(att, 1'b1)
      clr(16'h0800);
      wait_att(100);
      `CHK((n >= 24 && n <= 44), 1'b1)
      clr(16'h2100);
      rc(16'h0000);
      $display("test coarse and test mode done");

      sel_pwr = 1'b1;
      wait_att(20);
      `CHK(att, 1'b1)
      clr(16'h0800);
      cyc(2);
      `CHK(att, 1'b0)
      `CHK(req_count, 5)
      $display("test power input done");
      end_sim();
   end
endmodule // inactivity_monitor_timer_tb
